// ===== core/escape_ctrl.sv
// escape command interpreter driving lamps, buzzer and card interfaces
// assumes command and reply streams and card status inputs on i_clk
`timescale 1ns/1ps
module escape_ctrl #(
  parameter int unsigned BUZZ_UNIT = escape_ctrl_pkg::BUZZ_UNIT_CYCLES,
  parameter int unsigned HEARTBEAT = escape_ctrl_pkg::HEARTBEAT_CYCLES,
  parameter int unsigned HEART_WIDTH = 2_000_000,
  parameter int unsigned BLINK_HALF = 2_000_000,
  parameter int unsigned POLL_FAST = escape_ctrl_pkg::POLL_FAST_CYCLES,
  parameter int unsigned POLL_SLOW = escape_ctrl_pkg::POLL_SLOW_CYCLES,
  parameter logic [7:0] BEEP_UNITS = 8'h0a,
  // version text, first byte in the top bits; value is arbitrary
  parameter logic [159:0] VERSION_TEXT = {"RDR_CORE_V000", 56'h0}
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_cmd_last,
  output logic o_cmd_ready,
  output logic o_cmd_reject,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_last,
  input wire logic i_rsp_ready,
  input wire logic i_init_done,
  input wire logic i_card_event,
  input wire logic i_icc_active,
  input wire logic i_icc_busy,
  input wire logic i_picc_active,
  input wire logic i_picc_busy,
  input wire logic i_icc_reset_fail,
  input wire logic i_picc_a4_activated,
  output logic o_led_red,
  output logic o_led_green,
  output logic o_buzzer,
  output logic [2:0] o_refresh,
  output logic o_antenna_off,
  output logic [4:0] o_tag_enable,
  output logic o_auto_ats,
  output logic o_poll_start,
  output logic o_ats_request
);
  typedef enum logic [1:0] {ST_RX = 2'b00, ST_EXEC = 2'b01, ST_TX = 2'b10} state_t;
  state_t state;
  logic [1:0] rx_cnt;
  logic [7:0] op, rw, val;
  logic [7:0] led_byte, behav, refresh_mask, config_mode, picc_param;
  logic [7:0] buzz_units, reply_data;
  logic buzz_cont, is_version;
  logic [4:0] tx_idx;
  logic [31:0] buzz_div, heart_cnt, blink_cnt, poll_cnt;
  logic blink_phase;

  // frame decode
  wire is_write = (rw == escape_ctrl_pkg::RW_WRITE);
  wire is_read = (rw == escape_ctrl_pkg::RW_READ);
  wire known_op = (op == escape_ctrl_pkg::OP_LED) || (op == escape_ctrl_pkg::OP_BUZZER)
    || (op == escape_ctrl_pkg::OP_BEHAV) || (op == escape_ctrl_pkg::OP_REFRESH)
    || (op == escape_ctrl_pkg::OP_CONFIG) || (op == escape_ctrl_pkg::OP_PICC);
  wire op_version = (op == escape_ctrl_pkg::OP_VERSION);
  wire frame_ok = (rx_cnt == 2'd2 && is_read && (known_op || op_version))
    || (rx_cnt == 2'd3 && is_write && known_op);
  wire do_wr = (state == ST_EXEC) && frame_ok && is_write;
  wire wr_led = do_wr && op == escape_ctrl_pkg::OP_LED;
  wire wr_buzz = do_wr && op == escape_ctrl_pkg::OP_BUZZER;
  wire wr_behav = do_wr && op == escape_ctrl_pkg::OP_BEHAV;
  wire wr_refresh = do_wr && op == escape_ctrl_pkg::OP_REFRESH;
  wire wr_config = do_wr && op == escape_ctrl_pkg::OP_CONFIG;
  wire wr_picc = do_wr && op == escape_ctrl_pkg::OP_PICC;

  // reserved bits are dropped on the way in, so they read back as zero
  wire [7:0] led_in = val & escape_ctrl_pkg::LED_MASK;
  wire [7:0] behav_in = val & escape_ctrl_pkg::BEHAV_MASK;
  wire [7:0] refresh_in = val & escape_ctrl_pkg::REFRESH_MASK;
  wire [7:0] config_in = val & escape_ctrl_pkg::CONFIG_MASK;
  wire [7:0] buzz_state = buzz_cont ? escape_ctrl_pkg::BUZZ_ON : buzz_units;
  wire [7:0] buzz_after = (val == escape_ctrl_pkg::BUZZ_OFF) ? escape_ctrl_pkg::BUZZ_OFF : val;

  // reply payload byte reflects the value as stored after a write
  wire [7:0] next_reply =
      (op == escape_ctrl_pkg::OP_LED) ? (is_write ? led_in : led_byte) :
      (op == escape_ctrl_pkg::OP_BUZZER) ? (is_write ? buzz_after : buzz_state) :
      (op == escape_ctrl_pkg::OP_BEHAV) ? (is_write ? behav_in : behav) :
      (op == escape_ctrl_pkg::OP_REFRESH) ? (is_write ? refresh_in : refresh_mask) :
      (op == escape_ctrl_pkg::OP_CONFIG) ? (is_write ? config_in : config_mode) :
      (is_write ? val : picc_param);

  // reply stream: E1 00 00 00, length, payload
  wire [4:0] tx_last = is_version ? 5'(4 + escape_ctrl_pkg::VER_BYTES) : 5'd5;
  wire [4:0] tx_next = tx_idx + 5'd1;
  wire [4:0] ver_idx = tx_next - 5'd5;
  wire [7:0] ver_byte = VERSION_TEXT[8'(159 - 8 * ver_idx) -: 8];
  wire [7:0] len_byte = is_version ? 8'(escape_ctrl_pkg::VER_BYTES) : escape_ctrl_pkg::LEN_ONE;
  wire [7:0] next_tx_byte = (tx_next < 5'd4) ? escape_ctrl_pkg::HDR_REST :
    (tx_next == 5'd4) ? len_byte : (is_version ? ver_byte : reply_data);

  assign o_cmd_ready = (state == ST_RX);
  assign o_rsp_valid = (state == ST_TX);
  assign o_rsp_last = (state == ST_TX) && (tx_idx == tx_last);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= ST_RX;
      rx_cnt <= 2'd0;
      op <= 8'h00;
      rw <= 8'h00;
      val <= 8'h00;
      tx_idx <= 5'd0;
      o_rsp_byte <= 8'h00;
      o_cmd_reject <= 1'b0;
      reply_data <= 8'h00;
      is_version <= 1'b0;
    end else begin
      o_cmd_reject <= 1'b0;
      case (state)
        ST_RX: begin
          if (i_cmd_valid) begin
            if (rx_cnt == 2'd0) op <= i_cmd_byte;
            if (rx_cnt == 2'd1) rw <= i_cmd_byte;
            if (rx_cnt == 2'd2) val <= i_cmd_byte;
            if (rx_cnt != 2'd3) rx_cnt <= rx_cnt + 2'd1;
            if (i_cmd_last) state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          rx_cnt <= 2'd0;
          reply_data <= next_reply;
          is_version <= op_version;
          tx_idx <= 5'd0;
          o_rsp_byte <= escape_ctrl_pkg::HDR_FIRST;
          o_cmd_reject <= !frame_ok;
          state <= frame_ok ? ST_TX : ST_RX;
        end
        ST_TX: begin
          if (i_rsp_ready) begin
            tx_idx <= tx_next;
            o_rsp_byte <= next_tx_byte;
            if (o_rsp_last) state <= ST_RX;
          end
        end
        default: state <= ST_RX;
      endcase
    end
  end

  // stored control bytes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      led_byte <= 8'h00;
      behav <= escape_ctrl_pkg::BEHAV_RESET;
      refresh_mask <= 8'h00;
      config_mode <= 8'h00;
      picc_param <= escape_ctrl_pkg::PICC_RESET;
      o_refresh <= 3'b000;
    end else begin
      if (wr_led) led_byte <= led_in;
      if (wr_behav) behav <= behav_in;
      if (wr_refresh) refresh_mask <= refresh_in;
      if (wr_config) config_mode <= config_in;
      if (wr_picc) picc_param <= val;
      // bit 0 of this pulse is the contact card reset
      o_refresh <= wr_refresh ? refresh_in[2:0] : 3'b000;
    end
  end

  // buzzer: a unit divider restarts on every new duration
  wire buzz_tick = (buzz_div == 32'(BUZZ_UNIT - 1));
  wire auto_beep = i_init_done || (i_card_event && behav[escape_ctrl_pkg::B_EVT_BEEP]);
  wire beep_load = auto_beep && !buzz_cont && buzz_units == 8'h00;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      buzz_units <= 8'h00;
      buzz_cont <= 1'b0;
      buzz_div <= 32'd0;
    end else if (wr_buzz) begin
      buzz_cont <= (val == escape_ctrl_pkg::BUZZ_ON);
      buzz_units <= (val == escape_ctrl_pkg::BUZZ_ON) ? 8'h00 : val;
      buzz_div <= 32'd0;
    end else if (beep_load) begin
      buzz_units <= BEEP_UNITS;
      buzz_div <= 32'd0;
    end else begin
      buzz_div <= buzz_tick ? 32'd0 : buzz_div + 32'd1;
      if (buzz_tick && buzz_units != 8'h00) buzz_units <= buzz_units - 8'h01;
    end
  end
  assign o_buzzer = buzz_cont || (buzz_units != 8'h00);

  // lamp timing: heartbeat for the idle contactless lamp, blink while busy
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      heart_cnt <= 32'd0;
      blink_cnt <= 32'd0;
      blink_phase <= 1'b0;
    end else begin
      heart_cnt <= (heart_cnt == 32'(HEARTBEAT - 1)) ? 32'd0 : heart_cnt + 32'd1;
      blink_cnt <= (blink_cnt == 32'(BLINK_HALF - 1)) ? 32'd0 : blink_cnt + 32'd1;
      if (blink_cnt == 32'(BLINK_HALF - 1)) blink_phase <= !blink_phase;
    end
  end
  wire heart_on = (heart_cnt < 32'(HEART_WIDTH));
  wire blink_en = behav[escape_ctrl_pkg::B_BLINK];
  wire red_auto = i_picc_active
    ? (behav[escape_ctrl_pkg::B_PICC_IND] && (!(blink_en && i_picc_busy) || blink_phase))
    : (behav[escape_ctrl_pkg::B_POLL_IND] && heart_on);
  wire green_auto = i_icc_active && behav[escape_ctrl_pkg::B_ICC_IND]
    && (!(blink_en && i_icc_busy) || blink_phase);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_led_red <= 1'b0;
      o_led_green <= 1'b0;
    end else begin
      o_led_red <= led_byte[0] || red_auto;
      o_led_green <= led_byte[1] || green_auto;
    end
  end

  // contactless polling pacing
  wire [31:0] poll_period = picc_param[escape_ctrl_pkg::P_INTERVAL] ? 32'(POLL_FAST) : 32'(POLL_SLOW);
  wire poll_en = picc_param[escape_ctrl_pkg::P_AUTO_POLL];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      poll_cnt <= 32'd0;
      o_poll_start <= 1'b0;
      o_ats_request <= 1'b0;
      o_antenna_off <= 1'b0;
    end else begin
      o_poll_start <= poll_en && (poll_cnt >= poll_period - 32'd1);
      poll_cnt <= (!poll_en || poll_cnt >= poll_period - 32'd1) ? 32'd0 : poll_cnt + 32'd1;
      o_ats_request <= picc_param[escape_ctrl_pkg::P_AUTO_ATS] && i_picc_a4_activated;
      o_antenna_off <= (config_mode == 8'h00) && i_icc_reset_fail;
    end
  end
  assign o_tag_enable = picc_param[4:0];
  assign o_auto_ats = picc_param[escape_ctrl_pkg::P_AUTO_ATS];

  a_rw_reject: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == ST_EXEC && !frame_ok |=> o_cmd_reject && state == ST_RX && $stable(led_byte) && $stable(behav))
    else $error("bad frame not rejected");
  a_led_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_led |=> led_byte == ($past(val) & 8'h03) ##1 o_led_red == led_byte[0] || led_byte[0] == 1'b0)
    else $error("lamp write lost");
  a_reply_header: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == ST_EXEC && frame_ok |=> o_rsp_valid && o_rsp_byte == 8'he1)
    else $error("reply header wrong");
  a_buzz_cont: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_buzz && val == 8'hff |=> o_buzzer [*3])
    else $error("continuous buzz not held");
  a_buzz_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_buzz && val == 8'h00 && !auto_beep |=> !o_buzzer)
    else $error("buzzer not silenced");
  a_buzz_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state == ST_EXEC && frame_ok && op == 8'h28 && is_read |=> reply_data == $past(buzz_state))
    else $error("buzzer read wrong");
  a_refresh_icc: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_refresh && val[0] |=> o_refresh[0] ##1 !o_refresh[0])
    else $error("contact reset pulse wrong");
  a_antenna_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    config_mode == 8'h01 |=> !o_antenna_off)
    else $error("antenna off in manual mode");
  a_poll_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !poll_en && !$past(poll_en) |-> !o_poll_start)
    else $error("poll without enable");
  a_behav_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (behav & 8'h70) == 8'h00 && (led_byte & 8'hfc) == 8'h00)
    else $error("reserved bits stored");
  a_ats_req: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_picc_a4_activated && picc_param[6] && $stable(picc_param) |=> o_ats_request)
    else $error("ATS request missing");
endmodule : escape_ctrl

// ===== shared/escape_ctrl_pkg.sv
// constants for the reader escape command interpreter
// assumes a 20 MHz system clock and a byte-wide command/reply stream
// How it works
// - escape frame: function byte, then read/write byte
// - version query replies header, length, version text
// - lamp write updates lamps, replies lamp state
// - bit0 red, bit1 green; read returns same
// - buzzer: 0 off, 1-FE 10ms units, FF on
// - buzzer read returns state, buzzer untouched
// - behaviour bits 0-3 enable indications and beeps
// - behaviour bit7 blinks lamp during card access
// - behaviour byte resets 8F, written and read
// - refresh mask: contact, contactless, secure module
// - contact refresh bit resets the contact card
// - configure mode 00 auto antenna off, 01 not
// - contactless parameter resets FF, written and read
// - parameter bits 0-4 enable tag type detection
// - parameter bit5 picks 250 or 500 ms polling
// - parameter bit6 requests ATS on type A activation
// - parameter bit7 enables automatic polling
// - indication lamps: red contactless, green contact card
// - beep after power-up and on card events
package escape_ctrl_pkg;
  localparam logic [7:0] OP_VERSION = 8'h18;
  localparam logic [7:0] OP_LED = 8'h29;
  localparam logic [7:0] OP_BUZZER = 8'h28;
  localparam logic [7:0] OP_BEHAV = 8'h21;
  localparam logic [7:0] OP_REFRESH = 8'h2d;
  localparam logic [7:0] OP_CONFIG = 8'h2b;
  localparam logic [7:0] OP_PICC = 8'h20;
  localparam logic [7:0] RW_READ = 8'h00;
  localparam logic [7:0] RW_WRITE = 8'h01;
  localparam logic [7:0] HDR_FIRST = 8'he1;
  localparam logic [7:0] HDR_REST = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam int VER_BYTES = 20;
  localparam int VER_RSVD_BYTES = 10;
  localparam logic [7:0] LED_MASK = 8'h03;
  localparam logic [7:0] BEHAV_MASK = 8'h8f;
  localparam logic [7:0] REFRESH_MASK = 8'h07;
  localparam logic [7:0] CONFIG_MASK = 8'h01;
  localparam logic [7:0] BEHAV_RESET = 8'h8f;
  localparam logic [7:0] PICC_RESET = 8'hff;
  localparam logic [7:0] BUZZ_OFF = 8'h00;
  localparam logic [7:0] BUZZ_ON = 8'hff;
  localparam int B_ICC_IND = 0;
  localparam int B_POLL_IND = 1;
  localparam int B_PICC_IND = 2;
  localparam int B_EVT_BEEP = 3;
  localparam int B_BLINK = 7;
  localparam int P_INTERVAL = 5;
  localparam int P_AUTO_ATS = 6;
  localparam int P_AUTO_POLL = 7;
  localparam int CLK_HZ = 20_000_000;
  localparam int BUZZ_UNIT_MS = 10;
  localparam int HEARTBEAT_MS = 5000;
  localparam int POLL_FAST_MS = 250;
  localparam int POLL_SLOW_MS = 500;
  localparam int BUZZ_UNIT_CYCLES = CLK_HZ / 1000 * BUZZ_UNIT_MS;
  localparam int HEARTBEAT_CYCLES = CLK_HZ / 1000 * HEARTBEAT_MS;
  localparam int POLL_FAST_CYCLES = CLK_HZ / 1000 * POLL_FAST_MS;
  localparam int POLL_SLOW_CYCLES = CLK_HZ / 1000 * POLL_SLOW_MS;
endpackage : escape_ctrl_pkg

// ===== test/host_drv.sv
// host model: sends escape frames byte by byte and gathers reply bytes
// assumes the block's command and reply streams on i_clk
`timescale 1ns/1ps
module host_drv (
  input wire logic i_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic [7:0] i_rsp_byte,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_byte,
  output logic o_cmd_last,
  output logic o_rsp_ready
);
  logic [7:0] rx[$];
  bit slow = 1'b0;
  int timeouts = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_byte = 8'h5a;
    o_cmd_last = 1'b0;
    o_rsp_ready = 1'b1;
  end
  // a slow host takes a reply byte only every other cycle
  always @(posedge i_clk) o_rsp_ready <= #1 slow ? ~o_rsp_ready : 1'b1;
  always @(negedge i_clk) if (i_rsp_valid && o_rsp_ready) rx.push_back(i_rsp_byte);
  // frames go out whole, last byte flagged: function byte, access byte, value if given
  task automatic send(input logic [7:0] f[$]);
    int n;
    for (int i = 0; i < f.size(); i++) begin
      o_cmd_valid = 1'b1;
      o_cmd_byte = f[i];
      o_cmd_last = (i == f.size() - 1);
      n = 0;
      @(negedge i_clk);
      while (!i_cmd_ready && n < 50) begin
        @(negedge i_clk);
        n++;
      end
      if (n >= 50) timeouts++;
      @(posedge i_clk);
      #1;
    end
    o_cmd_valid = 1'b0;
    o_cmd_last = 1'b0;
    // released byte lane must not keep showing the last value
    o_cmd_byte = ~o_cmd_byte;
  endtask : send
endmodule : host_drv

// ===== test/tb_escape_ctrl.sv
// self-checking bench for the escape command interpreter
// assumes host_drv drives the command stream; long counts shortened
`timescale 1ns/1ps
module tb_escape_ctrl;
  localparam logic [159:0] VTXT = "TB_VERSION_STRING_20"; // arbitrary text
  logic i_clk = 0, i_rst_n = 0, init = 0, evt = 0, icc_act = 0, icc_busy = 0;
  logic picc_act = 0, picc_busy = 0, rst_fail = 0, a4 = 0;
  logic cmd_valid, cmd_last, cmd_ready, reject, rsp_valid, rsp_ready, rsp_last;
  logic red, green, buzz, ant_off, auto_ats, poll, ats_req;
  logic [7:0] cmd_byte, rsp_byte;
  logic [2:0] refresh, ref_seen;
  logic [4:0] tag_en;
  logic [7:0] st[logic [7:0]];
  logic [7:0] pv[2] = '{8'he5, 8'h9a};
  logic [7:0] bv[2] = '{8'h08, 8'h87};
  logic [7:0] ops[5] = '{8'h29, 8'h21, 8'h2d, 8'h2b, 8'h20};
  logic [31:0] seed = 32'hbb1c;
  int n_fail = 0, checks_done = 0, n_rej = 0, buz_hi = 0, red_hi = 0, gap = 0, last_gap = 0, n_last = 0;
  always #25 i_clk = ~i_clk;
  escape_ctrl #(.BUZZ_UNIT(10), .HEARTBEAT(100), .HEART_WIDTH(10), .BLINK_HALF(4), .POLL_FAST(20),
    .POLL_SLOW(40), .VERSION_TEXT(VTXT)) u_escape_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte), .i_cmd_last(cmd_last), .o_cmd_ready(cmd_ready),
    .o_cmd_reject(reject), .o_rsp_valid(rsp_valid), .o_rsp_byte(rsp_byte), .o_rsp_last(rsp_last),
    .i_rsp_ready(rsp_ready), .i_init_done(init), .i_card_event(evt), .i_icc_active(icc_act),
    .i_icc_busy(icc_busy), .i_picc_active(picc_act), .i_picc_busy(picc_busy),
    .i_icc_reset_fail(rst_fail), .i_picc_a4_activated(a4), .o_led_red(red), .o_led_green(green),
    .o_buzzer(buzz), .o_refresh(refresh), .o_antenna_off(ant_off), .o_tag_enable(tag_en),
    .o_auto_ats(auto_ats), .o_poll_start(poll), .o_ats_request(ats_req));
  host_drv u_host_drv (.i_clk(i_clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_byte(rsp_byte), .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte), .o_cmd_last(cmd_last),
    .o_rsp_ready(rsp_ready));
  always @(negedge i_clk) begin
    if (reject === 1'b1) n_rej++;
    if (rsp_last === 1'b1 && rsp_valid === 1'b1 && rsp_ready === 1'b1) n_last++;
    if (buzz === 1'b1) buz_hi++;
    if (red === 1'b1) red_hi++;
    if (refresh !== 3'b0) ref_seen = refresh;
    gap++;
    if (poll === 1'b1) begin
      last_gap = gap;
      gap = 0;
    end
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] msk(input logic [7:0] op);
    case (op)
      8'h29: return 8'h03;
      8'h21: return 8'h8f;
      8'h2d: return 8'h07;
      8'h2b: return 8'h01;
      default: return 8'hff;
    endcase
  endfunction : msk
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic pulse_in(input int which);
    init = which[3];
    evt = which[2];
    rst_fail = which[1];
    a4 = which[0];
    cyc(1);
    init = 1'b0;
    evt = 1'b0;
    rst_fail = 1'b0;
    a4 = 1'b0;
  endtask : pulse_in
  // one frame through the host model, reply judged against the stored-byte model
  task automatic xact(input logic [7:0] op, rw, val, input int nb);
    logic [7:0] f[$];
    logic [7:0] e[$];
    int r0;
    int l0;
    int k;
    bit ok;
    f = {op, rw, val, val};
    f = f[0:nb-1];
    ok = (nb == 2 && rw == 8'h00 && op inside {8'h18, 8'h29, 8'h28, 8'h21, 8'h2d, 8'h2b, 8'h20})
      || (nb == 3 && rw == 8'h01 && op inside {8'h29, 8'h28, 8'h21, 8'h2d, 8'h2b, 8'h20});
    if (ok && nb == 3) st[op] = val & msk(op);
    e = {8'he1, 8'h00, 8'h00, 8'h00, 8'h01, st.exists(op) ? st[op] : 8'h00};
    if (op == 8'h18) begin
      e[4] = 8'h14;
      e.pop_back();
      for (int i = 0; i < 20; i++) e.push_back(VTXT[159-8*i -: 8]);
    end
    if (!ok) e = {};
    r0 = n_rej;
    l0 = n_last;
    u_host_drv.rx = {};
    ref_seen = 3'b0;
    u_host_drv.send(f);
    k = 0;
    cyc(2);
    while (cmd_ready !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    if (k >= 200 || u_host_drv.timeouts > 0) begin
      n_fail++;
      final_report();
    end
    cyc(2);
    chk("reject", {7'b0, !ok}, 8'(n_rej - r0));
    chk("last", {7'b0, ok}, 8'(n_last - l0));
    chk("length", 8'(e.size()), 8'(u_host_drv.rx.size()));
    foreach (e[i]) chk("reply", e[i], u_host_drv.rx[i]);
  endtask : xact
  initial begin
    logic [7:0] v;
    st = '{8'h29: 8'h00, 8'h21: 8'h8f, 8'h2d: 8'h00, 8'h2b: 8'h00, 8'h20: 8'hff, 8'h28: 8'h00};
    cyc(8);
    i_rst_n = 1'b1;
    chk("tag_en", 8'h1f, {3'b0, tag_en});
    buz_hi = 0;
    pulse_in(8);
    cyc(120);
    chk("boot_beep", 8'd100, 8'(buz_hi));
    foreach (st[op]) xact(op, 8'h00, 8'h00, 2);
    xact(8'h18, 8'h00, 8'h00, 2);
    u_host_drv.slow = 1'b1;
    for (int i = 0; i < 15; i++) begin
      v = xs();
      xact(ops[i % 5], 8'h01, v, 3);
      if (ops[i % 5] == 8'h2d) chk("refresh", v & 8'h07, {5'b0, ref_seen});
      xact(ops[i % 5], 8'h00, 8'h00, 2);
    end
    u_host_drv.slow = 1'b0;
    xact(8'h21, 8'h01, 8'h00, 3);
    for (int i = 0; i < 4; i++) begin
      xact(8'h29, 8'h01, 8'(i), 3);
      chk("red", 8'(i & 1), {7'b0, red});
      chk("green", 8'(i >> 1), {7'b0, green});
    end
    xact(8'h33, 8'h00, 8'h00, 2);
    xact(8'h18, 8'h01, 8'h05, 3);
    xact(8'h29, 8'h01, 8'h00, 2);
    xact(8'h21, 8'h00, 8'h00, 3);
    xact(8'h29, 8'h00, 8'h00, 2);
    buz_hi = 0;
    xact(8'h28, 8'h01, 8'h03, 3);
    cyc(60);
    chk("buzz_units", 8'd30, 8'(buz_hi));
    st[8'h28] = 8'h00;
    xact(8'h28, 8'h00, 8'h00, 2);
    xact(8'h28, 8'h01, 8'hff, 3);
    xact(8'h28, 8'h00, 8'h00, 2);
    chk("buzz_on", 8'h01, {7'b0, buzz});
    xact(8'h28, 8'h01, 8'h00, 3);
    chk("buzz_off", 8'h00, {7'b0, buzz});
    for (int i = 0; i < 2; i++) begin
      xact(8'h2b, 8'h01, 8'(i), 3);
      xact(8'h20, 8'h01, i ? 8'h00 : 8'h40, 3);
      pulse_in(3);
      chk("antenna_off", 8'(1 - i), {7'b0, ant_off});
      chk("ats_req", 8'(1 - i), {7'b0, ats_req});
    end
    foreach (pv[i]) begin
      xact(8'h20, 8'h01, pv[i], 3);
      cyc(100);
      chk("poll_gap", pv[i][5] ? 8'd20 : 8'd40, 8'(last_gap));
      chk("tag_en", pv[i] & 8'h1f, {3'b0, tag_en});
      chk("auto_ats", {7'b0, pv[i][6]}, {7'b0, auto_ats});
    end
    xact(8'h20, 8'h01, 8'h00, 3);
    cyc(5);
    last_gap = 0;
    cyc(100);
    chk("poll_off", 8'd0, 8'(last_gap));
    foreach (bv[i]) begin
      xact(8'h21, 8'h01, bv[i], 3);
      buz_hi = 0;
      pulse_in(4);
      cyc(120);
      chk("evt_beep", bv[i][3] ? 8'd100 : 8'd0, 8'(buz_hi));
    end
    // manual lamps off, so only the automatic indication can light them
    xact(8'h29, 8'h01, 8'h00, 3);
    xact(8'h21, 8'h01, 8'h85, 3);
    picc_act = 1'b1;
    icc_act = 1'b1;
    cyc(3);
    chk("red_ind", 8'h01, {7'b0, red});
    chk("green_ind", 8'h01, {7'b0, green});
    picc_busy = 1'b1;
    icc_busy = 1'b1;
    red_hi = 0;
    cyc(40);
    chk("blink", 8'h01, 8'(red_hi > 0 && red_hi < 40));
    picc_act = 1'b0;
    icc_act = 1'b0;
    picc_busy = 1'b0;
    icc_busy = 1'b0;
    xact(8'h21, 8'h01, 8'h02, 3);
    red_hi = 0;
    cyc(250);
    chk("heartbeat", 8'h01, 8'(red_hi > 0 && red_hi < 250));
    final_report();
  end
endmodule : tb_escape_ctrl
